// ### rtl/rioc_top.sv
`default_nettype none
module rioc_top #(
  parameter logic [20:0] AUTO_REL_COUNT = 21'(rioc_pkg::AUTO_REL_CYC),
  parameter logic [23:0] MS_TICK_COUNT  = 24'(rioc_pkg::CYC_PER_MS)
) (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // register port
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  // event sources, one-cycle pulses on this clock
  input  wire logic       update_evt_in,
  input  wire logic       timer_evt_in,
  input  wire logic       alarm_evt_in,
  input  wire logic       event_evt_in,
  // chip enable pin, asynchronous
  input  wire logic       chip_en_in,
  // open-drain interrupt pin
  input  wire logic       irq_n_in,
  output logic            irq_n_out,
  output logic            irq_n_oe_n_out,
  // clock control and compensation timing
  output logic            clock_halt_out,
  output logic            subsec_clear_out,
  output logic      [1:0] comp_interval_sel_out,
  output logic            comp_tick_out
);
  logic [1:0] comp_interval_sel_r, comp_interval_sel_nxt;
  logic       update_irq_en_r, update_irq_en_nxt;
  logic       timer_irq_en_r, timer_irq_en_nxt;
  logic       alarm_irq_en_r, alarm_irq_en_nxt;
  logic       event_irq_en_r, event_irq_en_nxt;
  logic       reset_bit_r, reset_bit_nxt;
  logic       update_flag_r, update_flag_nxt;
  logic       timer_flag_r, timer_flag_nxt;
  logic       alarm_flag_r, alarm_flag_nxt;
  logic       event_flag_r, event_flag_nxt;
  logic       alarm_req_r, alarm_req_nxt;
  logic       event_req_r, event_req_nxt;
  logic       subsec_clear_r, subsec_clear_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic       ce_meta_r, ce_sync_r;
  logic [23:0] ms_cnt_r, ms_cnt_nxt;
  logic [15:0] comp_ms_r, comp_ms_nxt;
  logic       comp_tick_r, comp_tick_nxt;
  logic       ctrl_wr, flag_wr, ctrl_rd, flag_rd;
  logic       upd_start, tmr_start;
  logic       upd_busy, tmr_busy;
  logic       pin_low;
  logic [15:0] comp_period_ms;

  // irq_n_in is unused: the pin is only driven, never sensed
  always_comb begin
    ctrl_wr = 1'b0;
    flag_wr = 1'b0;
    ctrl_rd = 1'b0;
    flag_rd = 1'b0;
    if (addr_in == rioc_pkg::RIOC_CTRL_ADDR || addr_in == rioc_pkg::RIOC_CTRL_MIRROR) begin
      ctrl_wr = wr_in;
      ctrl_rd = rd_in;
    end else if (addr_in == rioc_pkg::RIOC_FLAG_ADDR || addr_in == rioc_pkg::RIOC_FLAG_MIRROR) begin
      flag_wr = wr_in;
      flag_rd = rd_in;
    end
  end

  // flags: an event in the clearing cycle wins over the clear
  always_comb begin
    update_flag_nxt = update_flag_r;
    timer_flag_nxt  = timer_flag_r;
    alarm_flag_nxt  = alarm_flag_r;
    event_flag_nxt  = event_flag_r;
    if (flag_wr) begin
      update_flag_nxt = update_flag_r & wdata_in[rioc_pkg::UPD_FLAG_BIT];
      timer_flag_nxt  = timer_flag_r & wdata_in[rioc_pkg::TMR_FLAG_BIT];
      alarm_flag_nxt  = alarm_flag_r & wdata_in[rioc_pkg::ALM_FLAG_BIT];
      event_flag_nxt  = event_flag_r & wdata_in[rioc_pkg::EVT_FLAG_BIT];
    end
    if (update_evt_in) update_flag_nxt = 1'b1;
    if (timer_evt_in) timer_flag_nxt = 1'b1;
    if (alarm_evt_in) alarm_flag_nxt = 1'b1;
    if (event_evt_in) event_flag_nxt = 1'b1;
  end

  always_comb begin
    comp_interval_sel_nxt = comp_interval_sel_r;
    update_irq_en_nxt     = update_irq_en_r;
    timer_irq_en_nxt      = timer_irq_en_r;
    alarm_irq_en_nxt      = alarm_irq_en_r;
    event_irq_en_nxt      = event_irq_en_r;
    reset_bit_nxt         = reset_bit_r;
    subsec_clear_nxt      = 1'b0;
    if (ctrl_wr) begin
      comp_interval_sel_nxt = wdata_in[rioc_pkg::ISEL_HI:rioc_pkg::ISEL_LO];
      update_irq_en_nxt     = wdata_in[rioc_pkg::UPD_EN_BIT];
      timer_irq_en_nxt      = wdata_in[rioc_pkg::TMR_EN_BIT];
      alarm_irq_en_nxt      = wdata_in[rioc_pkg::ALM_EN_BIT];
      event_irq_en_nxt      = wdata_in[rioc_pkg::EVT_EN_BIT];
      reset_bit_nxt         = wdata_in[rioc_pkg::RST_BIT];
      subsec_clear_nxt      = wdata_in[rioc_pkg::RST_BIT];
    end else if (!ce_sync_r) begin
      reset_bit_nxt = 1'b0;
    end
  end

  // request starts on the flag's rising edge with enable set
  assign upd_start = update_evt_in & ~update_flag_r & update_irq_en_r;
  assign tmr_start = timer_evt_in & ~timer_flag_r & timer_irq_en_r;

  rioc_release_timer #(
    .CW    (21),
    .COUNT (AUTO_REL_COUNT)
  ) u_upd_rel (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .start_in  (upd_start),
    .cancel_in (~update_irq_en_r),
    .busy_out  (upd_busy)
  );

  // flag clear leaves this one alone
  rioc_release_timer #(
    .CW    (21),
    .COUNT (AUTO_REL_COUNT)
  ) u_tmr_rel (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .start_in  (tmr_start),
    .cancel_in (~timer_irq_en_r),
    .busy_out  (tmr_busy)
  );

  always_comb begin
    alarm_req_nxt = alarm_req_r;
    event_req_nxt = event_req_r;
    if (alarm_evt_in && !alarm_flag_r && alarm_irq_en_r) begin
      alarm_req_nxt = 1'b1;
    end else if (!alarm_flag_r || !alarm_irq_en_r) begin
      alarm_req_nxt = 1'b0;
    end
    if (event_evt_in && !event_flag_r && event_irq_en_r) begin
      event_req_nxt = 1'b1;
    end else if (!event_flag_r || !event_irq_en_r) begin
      event_req_nxt = 1'b0;
    end
  end

  // enables also gate here so a cleared enable drops the pin at once
  assign pin_low = (upd_busy & update_irq_en_r) | (tmr_busy & timer_irq_en_r)
                 | (alarm_req_r & alarm_irq_en_r) | (event_req_r & event_irq_en_r);

  // compensation period tick from a millisecond divider
  always_comb begin
    case (comp_interval_sel_r)
      rioc_pkg::ISEL_0P5S: comp_period_ms = 16'(rioc_pkg::COMP_0P5_MS);
      rioc_pkg::ISEL_2S:   comp_period_ms = 16'(rioc_pkg::COMP_2_MS);
      rioc_pkg::ISEL_10S:  comp_period_ms = 16'(rioc_pkg::COMP_10_MS);
      default:             comp_period_ms = 16'(rioc_pkg::COMP_30_MS);
    endcase
  end

  always_comb begin
    ms_cnt_nxt    = ms_cnt_r + 24'h1;
    comp_ms_nxt   = comp_ms_r;
    comp_tick_nxt = 1'b0;
    if (ms_cnt_r >= MS_TICK_COUNT - 24'h1) begin
      ms_cnt_nxt = '0;
      if (comp_ms_r >= comp_period_ms - 16'h1) begin
        comp_ms_nxt   = '0;
        comp_tick_nxt = 1'b1;
      end else begin
        comp_ms_nxt = comp_ms_r + 16'h1;
      end
    end
  end

  always_comb begin
    rdata_nxt = 8'h00;
    if (ctrl_rd) begin
      rdata_nxt = {comp_interval_sel_r, update_irq_en_r, timer_irq_en_r,
                   alarm_irq_en_r, event_irq_en_r, 1'b0, reset_bit_r};
    end else if (flag_rd) begin
      rdata_nxt = {2'b00, update_flag_r, timer_flag_r, alarm_flag_r, event_flag_r, 2'b00};
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      comp_interval_sel_r <= rioc_pkg::ISEL_RESET;
      update_irq_en_r     <= 1'b0;
      timer_irq_en_r      <= 1'b0;
      alarm_irq_en_r      <= 1'b0;
      event_irq_en_r      <= 1'b0;
      reset_bit_r         <= 1'b0;
      update_flag_r       <= 1'b0;
      timer_flag_r        <= 1'b0;
      alarm_flag_r        <= 1'b0;
      event_flag_r        <= 1'b0;
      alarm_req_r         <= 1'b0;
      event_req_r         <= 1'b0;
      subsec_clear_r      <= 1'b0;
      rdata_r             <= 8'h00;
      ce_meta_r           <= 1'b1;
      ce_sync_r           <= 1'b1;
      ms_cnt_r            <= '0;
      comp_ms_r           <= '0;
      comp_tick_r         <= 1'b0;
    end else begin
      comp_interval_sel_r <= comp_interval_sel_nxt;
      update_irq_en_r     <= update_irq_en_nxt;
      timer_irq_en_r      <= timer_irq_en_nxt;
      alarm_irq_en_r      <= alarm_irq_en_nxt;
      event_irq_en_r      <= event_irq_en_nxt;
      reset_bit_r         <= reset_bit_nxt;
      update_flag_r       <= update_flag_nxt;
      timer_flag_r        <= timer_flag_nxt;
      alarm_flag_r        <= alarm_flag_nxt;
      event_flag_r        <= event_flag_nxt;
      alarm_req_r         <= alarm_req_nxt;
      event_req_r         <= event_req_nxt;
      subsec_clear_r      <= subsec_clear_nxt;
      rdata_r             <= rdata_nxt;
      ce_meta_r           <= chip_en_in;
      ce_sync_r           <= ce_meta_r;
      ms_cnt_r            <= ms_cnt_nxt;
      comp_ms_r           <= comp_ms_nxt;
      comp_tick_r         <= comp_tick_nxt;
    end
  end

  assign rdata_out             = rdata_r;
  assign irq_n_out             = 1'b0;
  assign irq_n_oe_n_out        = ~pin_low;
  assign clock_halt_out        = reset_bit_r;
  assign subsec_clear_out      = subsec_clear_r;
  assign comp_interval_sel_out = comp_interval_sel_r;
  assign comp_tick_out         = comp_tick_r;
endmodule
`default_nettype wire

// ### rtl/rioc_pkg.sv
// Summary of operation
// - control register at two mirrored offsets; bit 1 reads zero, ignores writes
// - after power-up interval field holds 2.0 s code, bit 1 reads zero
// - interval code 00/01/10/11 selects 0.5, 2.0, 10, 30 seconds
// - update flag rise with enable drives pin low, else pin stays released
// - clearing update enable blocks and cancels update-driven low
// - update low releases itself 7.8 ms after the event
// - timer flag rise with enable drives low; clearing enable cancels it
// - timer low releases itself no later than 7.8 ms after the event
// - alarm flag rise with enable drives low; clearing enable cancels it
// - alarm low holds until alarm flag is cleared
// - pin is the OR of all enabled active requests
// - with update, timer, alarm enables zero those sources never drive low
// - event flag rise with enable drives low, else released
// - bit 0 of control governs whether counting runs or stops
// - writing 1 to reset bit clears sub-second stages, halts; chip enable low releases
// - each flag sets on its event and holds until host writes 0
// - clearing timer flag does not change a timer-driven low
`default_nettype none
package rioc_pkg;
  localparam logic [7:0] RIOC_CTRL_ADDR   = 8'h0f;
  localparam logic [7:0] RIOC_CTRL_MIRROR = 8'h1f;
  localparam logic [7:0] RIOC_FLAG_ADDR   = 8'h0e;
  localparam logic [7:0] RIOC_FLAG_MIRROR = 8'h1e;
  localparam int ISEL_HI      = 7;
  localparam int ISEL_LO      = 6;
  localparam int UPD_EN_BIT   = 5;
  localparam int TMR_EN_BIT   = 4;
  localparam int ALM_EN_BIT   = 3;
  localparam int EVT_EN_BIT   = 2;
  localparam int RST_BIT      = 0;
  localparam int UPD_FLAG_BIT = 5;
  localparam int TMR_FLAG_BIT = 4;
  localparam int ALM_FLAG_BIT = 3;
  localparam int EVT_FLAG_BIT = 2;
  localparam logic [1:0] ISEL_RESET = 2'h1;
  localparam logic [1:0] ISEL_0P5S  = 2'h0;
  localparam logic [1:0] ISEL_2S    = 2'h1;
  localparam logic [1:0] ISEL_10S   = 2'h2;
  localparam logic [1:0] ISEL_30S   = 2'h3;
  localparam longint CLK_HZ = 250000000;
  localparam longint AUTO_REL_NS = 7800000;
  localparam longint AUTO_REL_CYC = (AUTO_REL_NS * CLK_HZ) / 1000000000;
  localparam longint COMP_0P5_MS = 500;
  localparam longint COMP_2_MS   = 2000;
  localparam longint COMP_10_MS  = 10000;
  localparam longint COMP_30_MS  = 30000;
  localparam longint CYC_PER_MS  = CLK_HZ / 1000;
endpackage
`default_nettype wire

// ### rtl/rioc_release_timer.sv
`default_nettype none
// per-source release timer; count loads on start, busy_out clears when the count reaches one
module rioc_release_timer #(
  parameter int unsigned CW    = 21,
  parameter logic [20:0] COUNT = 21'h1dc130
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic start_in,
  input  wire logic cancel_in,
  output logic      busy_out
);
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          busy_r;
  logic          busy_nxt;

  always_comb begin
    cnt_nxt  = cnt_r;
    busy_nxt = busy_r;
    if (start_in) begin
      cnt_nxt  = COUNT[CW-1:0];
      busy_nxt = 1'b1;
    end else if (cancel_in) begin
      busy_nxt = 1'b0;
    end else if (busy_r) begin
      if (cnt_r <= {{(CW-1){1'b0}}, 1'b1}) begin
        busy_nxt = 1'b0;
      end else begin
        cnt_nxt = cnt_r - {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_r  <= '0;
      busy_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign busy_out = busy_r;
endmodule
`default_nettype wire

// ### dv/rioc_host_model.sv
`default_nettype none
module rioc_host_model (
  input  wire logic irq_n_in,
  input  wire logic irq_n_oe_n_in,
  output logic      pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // board pull-up: a released pin reads high, never the last driven value
  assign pin_out = irq_n_oe_n_in ? 1'b1 : irq_n_in;
endmodule
`default_nettype wire

// ### dv/rioc_monitor.sv
`default_nettype none
module rioc_monitor (
  input wire logic       clk_in,
  input wire logic       rst_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic       update_evt_in,
  input wire logic       timer_evt_in,
  input wire logic       alarm_evt_in,
  input wire logic       event_evt_in,
  input wire logic       irq_n_out,
  input wire logic       irq_n_oe_n_out,
  input wire logic       clock_halt_out,
  input wire logic       subsec_clear_out,
  input wire logic [1:0] comp_interval_sel_out,
  input wire logic       comp_tick_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // shadow of the control bits; bit 0 skipped since chip enable clears it
  logic [7:2] sh_r;
  logic [7:2] sh_nxt;
  logic       cw;
  logic [3:0] req;
  assign cw = wr_in && (addr_in == 8'h0f || addr_in == 8'h1f);
  assign req = {update_evt_in, timer_evt_in, alarm_evt_in, event_evt_in} & sh_r[5:2];
  always_comb begin
    sh_nxt = sh_r;
    if (cw) sh_nxt = wdata_in[7:2];
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) sh_r <= 6'h10;
    else sh_r <= sh_nxt;
  end
  pin_drive_a: assert property (irq_n_out == 1'b0) else $error("pin drive value not low");
  src_or_a: assert property ($fell(irq_n_oe_n_out) |-> $past(req != 4'h0))
    else $error("pin fell without enabled request");
  quiet_a: assert property (sh_r[5:2] == 4'h0 |-> irq_n_oe_n_out) else $error("pin low with enables off");
  drop_a: assert property (cw && wdata_in[5:2] == 4'h0 |=> irq_n_oe_n_out)
    else $error("enable clear did not release pin");
  sel_map_a: assert property (comp_interval_sel_out == sh_r[7:6]) else $error("interval select wrong");
  rst_val_a: assert property ($fell(rst_in) |-> comp_interval_sel_out == 2'h1 && irq_n_oe_n_out)
    else $error("reset state wrong");
  halt_set_a: assert property (cw && wdata_in[0] |=> clock_halt_out && subsec_clear_out ##1 !subsec_clear_out)
    else $error("halt or clear pulse wrong");
  ctrl_read_a: assert property (rd_in && (addr_in == 8'h0f || addr_in == 8'h1f) |=>
    rdata_out[7:2] == $past(sh_r) && !rdata_out[1]) else $error("control read wrong");
  tick_one_a: assert property (comp_tick_out |=> !comp_tick_out) else $error("tick longer than one cycle");
endmodule
bind rioc_top rioc_monitor u_mon (
  .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .update_evt_in(update_evt_in), .timer_evt_in(timer_evt_in),
  .alarm_evt_in(alarm_evt_in), .event_evt_in(event_evt_in), .irq_n_out(irq_n_out),
  .irq_n_oe_n_out(irq_n_oe_n_out), .clock_halt_out(clock_halt_out), .subsec_clear_out(subsec_clear_out),
  .comp_interval_sel_out(comp_interval_sel_out), .comp_tick_out(comp_tick_out));
`default_nettype wire

// ### dv/rioc_top_bench.sv
`default_nettype none
module rioc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NREL = 20;
  logic       clk_in, rst_in, wr, rd, chip_en, pin, drv, oe_n, halt, sub, tick;
  logic [7:0] addr, wdata, rdata;
  logic [3:0] evt;
  logic [1:0] sel;
  int         n_mismatch = 0, check_count = 0, cycles = 0, n;
  rioc_top #(.AUTO_REL_COUNT(21'(NREL)), .MS_TICK_COUNT(24'h4)) dut (
    .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .update_evt_in(evt[3]), .timer_evt_in(evt[2]), .alarm_evt_in(evt[1]),
    .event_evt_in(evt[0]), .chip_en_in(chip_en), .irq_n_in(pin), .irq_n_out(drv),
    .irq_n_oe_n_out(oe_n), .clock_halt_out(halt), .subsec_clear_out(sub),
    .comp_interval_sel_out(sel), .comp_tick_out(tick));
  rioc_host_model host (.irq_n_in(drv), .irq_n_oe_n_in(oe_n), .pin_out(pin));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %0h seen %0h", s, e, g);
    end
  endtask
  task automatic chkp(input logic e);
    chk("pin", {31'h0, e}, {31'h0, pin});
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask
  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_in);
    addr <= a; rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 chk("rdata", {24'h0, e}, {24'h0, rdata});
  endtask
  task automatic pulse(input int i);
    @(posedge clk_in);
    evt[i] <= 1'b1;
    @(posedge clk_in);
    evt <= 4'h0;
    #1;
  endtask
  task automatic t_update();
    wrr(8'h1f, 8'h62);
    rdc(8'h0f, 8'h60);
    pulse(3);
    chkp(1'b0);
    rdc(8'h0e, 8'h20);
    cyc(NREL - 3);
    chkp(1'b0);
    cyc(1);
    chkp(1'b1);
    wrr(8'h0e, 8'h00);
    pulse(3);
    chkp(1'b0);
    wrr(8'h0f, 8'h40);
    cyc(0);
    chkp(1'b1);
    wrr(8'h0e, 8'h00);
  endtask
  task automatic t_timer();
    wrr(8'h0f, 8'h50);
    pulse(2);
    chkp(1'b0);
    wrr(8'h0e, 8'h00);
    cyc(0);
    chkp(1'b0);
    cyc(NREL - 2);
    chkp(1'b1);
    pulse(2);
    chkp(1'b0);
    wrr(8'h0f, 8'h40);
    cyc(0);
    chkp(1'b1);
    wrr(8'h0e, 8'h00);
  endtask
  task automatic t_alarm();
    wrr(8'h0f, 8'h4c);
    pulse(1);
    chkp(1'b0);
    pulse(0);
    cyc(2 * NREL);
    chkp(1'b0);
    wrr(8'h0e, 8'h04);
    cyc(1);
    chkp(1'b0);
    rdc(8'h0e, 8'h04);
    wrr(8'h0f, 8'h48);
    cyc(0);
    chkp(1'b1);
    pulse(1);
    chkp(1'b0);
    wrr(8'h0e, 8'h00);
    cyc(1);
    chkp(1'b1);
  endtask
  task automatic t_poll();
    wrr(8'h0f, 8'h40);
    for (int i = 0; i < 4; i++) begin
      pulse(i);
      chkp(1'b1);
    end
    rdc(8'h1e, 8'h3c);
    wrr(8'h0e, 8'h00);
  endtask
  task automatic t_halt();
    wrr(8'h0f, 8'h41);
    cyc(0);
    chk("subsec", 1, sub);
    chk("halt", 1, halt);
    rdc(8'h0f, 8'h41);
    @(posedge clk_in);
    chip_en <= 1'b0;
    cyc(5);
    chk("halt", 0, halt);
    rdc(8'h0f, 8'h40);
    @(posedge clk_in);
    chip_en <= 1'b1;
  endtask
  task automatic t_comp();
    for (int i = 3; i >= 0; i--) begin
      wrr(8'h0f, {2'(i), 6'h0});
      cyc(0);
      chk("sel", i, sel);
    end
    // measured tick to tick so the phase left by the write does not matter
    for (n = 0; n < 3000 && tick !== 1'b1; n++) cyc(1);
    for (n = 1; n < 3000; n++) begin
      cyc(1);
      if (tick === 1'b1) break;
    end
    chk("tick period", 4 * 500, n);
  endtask
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      stop_test();
    end
  end
  initial begin
    rst_in = 1'b1; addr = 8'h00; wdata = 8'h00; wr = 1'b0; rd = 1'b0; evt = 4'h0; chip_en = 1'b1;
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    rdc(8'h0f, 8'h40);
    rdc(8'h30, 8'h00);
    chkp(1'b1);
    t_update();
    t_timer();
    t_alarm();
    t_poll();
    t_halt();
    t_comp();
    stop_test();
  end
endmodule
`default_nettype wire
